// *** dcd_decoder.sv ***
// command decoder and pin control of a ddr3 memory device
// assumes pins in the link clock domain; core side on clock, 10 MHz
`include "dcd_regs.svh"
module dcd_decoder (
    // core clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link clock and command pins
    input wire logic link_clock,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`DCD_BA_W-1:0] bank_addr,
    input wire logic [`DCD_ADDR_W-1:0] addr,
    input wire logic odt,
    // data pins and byte masks
    input wire logic [`DCD_DQ_W-1:0] dq_in,
    output logic [`DCD_DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    // read data from the core
    input wire logic [`DCD_DQ_W-1:0] rd_data,
    input wire logic rd_valid,
    // decoded results, core domain
    output dcd_pkg::dcd_cmd_e cmd,
    output logic cmd_valid,
    output logic [`DCD_BA_W-1:0] cmd_bank,
    output logic [`DCD_ADDR_W-1:0] cmd_addr,
    output logic [3:0] cmd_burst,
    output logic cmd_autopre,
    output logic [`DCD_BANKS-1:0] bank_open,
    output dcd_pkg::dcd_pwr_e pwr_state,
    output logic odt_on,
    output logic [`DCD_DQ_W-1:0] wr_data,
    output logic [1:0] wr_byte_en,
    output logic wr_valid
);
    import dcd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // reset: async assert, released through two flops per domain
    logic rst_a, rst_b, lrst_a, lrst_b;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_a <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_b <= rst_a;
        end
    end
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            lrst_a <= 1'b0;
            lrst_b <= 1'b0;
        end else begin
            lrst_a <= 1'b1;
            lrst_b <= lrst_a;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers on the link clock
    logic [4:0] ctl_s1, ctl_s2;
    logic [`DCD_BA_W-1:0] ba_s1, ba_s2;
    logic [`DCD_ADDR_W-1:0] ad_s1, ad_s2;
    logic odt_s1, odt_s2, cke_prev;
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b) begin
            ctl_s1 <= 5'h1e;
            ctl_s2 <= 5'h1e;
            ba_s1 <= '0;
            ba_s2 <= '0;
            ad_s1 <= '0;
            ad_s2 <= '0;
            odt_s1 <= 1'b0;
            odt_s2 <= 1'b0;
            cke_prev <= 1'b1;
        end else begin
            ctl_s1 <= {cke, cs_n, ras_n, cas_n, we_n};
            ctl_s2 <= ctl_s1;
            ba_s1 <= bank_addr;
            ba_s2 <= ba_s1;
            ad_s1 <= addr;
            ad_s2 <= ad_s1;
            odt_s1 <= odt;
            odt_s2 <= odt_s1;
            cke_prev <= ctl_s2[4];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode registers one and two, power and bank state (link domain)
    logic [`DCD_ADDR_W-1:0] mode_register_one, mode_register_two;
    logic [`DCD_BANKS-1:0] open_l;
    dcd_pwr_e pwr_l;
    dcd_cmd_e next_cmd;
    logic ck_n, cs, rs, cs2, we;
    logic bank_idle, all_idle;
    always_comb begin
        ck_n = ctl_s2[4];
        cs = ctl_s2[3];
        rs = ctl_s2[2];
        cs2 = ctl_s2[1];
        we = ctl_s2[0];
        bank_idle = !open_l[ba_s2];
        all_idle = (open_l == '0);
        next_cmd = dcd_nop;
        if (pwr_l != dcd_st_run) begin
            // exit needs rising enable with nop or deselect
            if (!cke_prev && ck_n && (cs || (rs && cs2 && we)))
                next_cmd = dcd_pdx;
            else
                next_cmd = dcd_des;
        end else if (cke_prev && !ck_n) begin
            // falling enable: self refresh, or power down on nop/deselect
            if (!cs && !rs && !cs2 && we && all_idle)
                next_cmd = dcd_sre;
            else if ((cs || (rs && cs2 && we)) && all_idle)
                next_cmd = dcd_pde;
            else
                next_cmd = cs ? dcd_des : dcd_ill;
        end else if (cs) begin
            next_cmd = dcd_des;
        end else if (!cke_prev || !ck_n) begin
            next_cmd = dcd_ill;
        end else begin
            case ({rs, cs2, we})
                3'b011: next_cmd = bank_idle ? dcd_act : dcd_ill;
                3'b010: next_cmd = ad_s2[`DCD_AP_BIT] ? dcd_prea : dcd_pre;
                3'b100: next_cmd = bank_idle ? dcd_ill : dcd_wr;
                3'b101: next_cmd = bank_idle ? dcd_ill : dcd_rd;
                3'b000: next_cmd = all_idle ? dcd_mrs : dcd_ill;
                3'b001: next_cmd = all_idle ? dcd_ref : dcd_ill;
                3'b110: next_cmd = !all_idle ? dcd_ill :
                    (ad_s2[`DCD_AP_BIT] ? dcd_zqcl : dcd_zqcs);
                3'b111: next_cmd = dcd_nop;
                default: next_cmd = dcd_ill;
            endcase
        end
    end

    // per-bank open state, one flop per bank
    genvar gi;
    generate
        for (gi = 0; gi < `DCD_BANKS; gi++) begin : g_bank
            always_ff @(posedge link_clock or negedge lrst_b) begin
                if (!lrst_b) begin
                    open_l[gi] <= 1'b0;
                end else if (next_cmd == dcd_prea) begin
                    open_l[gi] <= 1'b0;
                end else if (ba_s2 == gi) begin
                    if (next_cmd == dcd_act)
                        open_l[gi] <= 1'b1;
                    else if (next_cmd == dcd_pre)
                        open_l[gi] <= 1'b0;
                    else if ((next_cmd == dcd_wr || next_cmd == dcd_rd) &&
                             ad_s2[`DCD_AP_BIT])
                        open_l[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // power state
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b)
            pwr_l <= dcd_st_run;
        else if (next_cmd == dcd_sre)
            pwr_l <= dcd_st_sr;
        else if (next_cmd == dcd_pde)
            pwr_l <= dcd_st_pd;
        else if (next_cmd == dcd_pdx)
            pwr_l <= dcd_st_run;
    end

    // mode register loads
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b) begin
            mode_register_one <= '0;
            mode_register_two <= '0;
        end else if (next_cmd == dcd_mrs) begin
            if (ba_s2 == `DCD_MR_ONE)
                mode_register_one <= ad_s2;
            if (ba_s2 == `DCD_MR_TWO)
                mode_register_two <= ad_s2;
        end
    end

    // termination gate, link domain
    logic rtt_any, odt_l;
    always_comb begin
        rtt_any = mode_register_one[`DCD_RTT_NOM_A] |
            mode_register_one[`DCD_RTT_NOM_B] |
            mode_register_one[`DCD_RTT_NOM_C] |
            mode_register_two[`DCD_RTT_WR_LO] |
            mode_register_two[`DCD_RTT_WR_HI];
    end
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b)
            odt_l <= 1'b0;
        else
            odt_l <= odt_s2 & rtt_any;
    end

    ////////////////////////////////////////////////////////////////////
    // command word held and passed by toggle handshake to core
    logic [3:0] hold_cmd, hold_burst;
    logic [`DCD_BA_W-1:0] hold_ba;
    logic [`DCD_ADDR_W-1:0] hold_ad;
    logic hold_ap, tog_l;
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b) begin
            hold_cmd <= 4'h0;
            hold_burst <= `DCD_BL8;
            hold_ba <= '0;
            hold_ad <= '0;
            hold_ap <= 1'b0;
            tog_l <= 1'b0;
        end else if (next_cmd != dcd_nop && next_cmd != dcd_des) begin
            hold_cmd <= next_cmd;
            hold_ba <= ba_s2;
            hold_ad <= ad_s2;
            hold_ap <= ad_s2[`DCD_AP_BIT];
            // burst: fixed 8/chop 4 or on-the-fly via address twelve
            if (mode_register_one[1:0] == 2'b01)
                hold_burst <= ad_s2[`DCD_BC_BIT] ? `DCD_BL8 : `DCD_BC4;
            else if (mode_register_one[1:0] == 2'b10)
                hold_burst <= `DCD_BC4;
            else
                hold_burst <= `DCD_BL8;
            tog_l <= ~tog_l;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write data capture on both link clock edges, per byte mask
    logic [`DCD_DQ_W-1:0] dq_r, dq_f;
    logic [1:0] dm_r, dm_f;
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b) begin
            dq_r <= '0;
            dm_r <= 2'b11;
        end else begin
            dq_r <= dq_in;
            dm_r <= {upper_byte_mask, lower_byte_mask};
        end
    end
    always_ff @(negedge link_clock or negedge lrst_b) begin
        if (!lrst_b) begin
            dq_f <= '0;
            dm_f <= 2'b11;
        end else begin
            dq_f <= dq_in;
            dm_f <= {upper_byte_mask, lower_byte_mask};
        end
    end
    // falling-edge beat alone forms the word, byte enables active low mask
    logic [`DCD_DQ_W-1:0] beat_l;
    logic [1:0] ben_l;
    logic wtog_l, wr_act;
    assign wr_act = (open_l != '0) && pwr_l == dcd_st_run;
    always_ff @(posedge link_clock or negedge lrst_b) begin
        if (!lrst_b) begin
            beat_l <= '0;
            ben_l <= 2'b00;
            wtog_l <= 1'b0;
        end else if (wr_act && dm_f != 2'b11) begin
            beat_l <= dq_f;
            ben_l <= ~dm_f;
            wtog_l <= ~wtog_l;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core domain: synchronise toggles and levels
    logic [2:0] t1, t2, t3;
    logic [`DCD_BANKS-1:0] open_s1;
    logic [2:0] lev_s1;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            t1 <= 3'h0;
            t2 <= 3'h0;
            t3 <= 3'h0;
            open_s1 <= '0;
            lev_s1 <= 3'h0;
            bank_open <= '0;
            pwr_state <= dcd_st_run;
            odt_on <= 1'b0;
        end else begin
            t1 <= {wtog_l, tog_l, 1'b0};
            t2 <= t1;
            t3 <= t2;
            open_s1 <= open_l;
            bank_open <= open_s1;
            lev_s1 <= {pwr_l, odt_l};
            pwr_state <= dcd_pwr_e'(lev_s1[2:1]);
            odt_on <= lev_s1[0];
        end
    end

    // command outputs, one pulse per handshake edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= dcd_nop;
            cmd_valid <= 1'b0;
            cmd_bank <= '0;
            cmd_addr <= '0;
            cmd_burst <= `DCD_BL8;
            cmd_autopre <= 1'b0;
        end else begin
            cmd_valid <= t2[1] ^ t3[1];
            if (t2[1] ^ t3[1]) begin
                cmd <= dcd_cmd_e'(hold_cmd);
                cmd_bank <= hold_ba;
                cmd_addr <= hold_ad;
                cmd_burst <= hold_burst;
                cmd_autopre <= hold_ap;
            end
        end
    end

    // write data outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_data <= '0;
            wr_byte_en <= 2'b00;
            wr_valid <= 1'b0;
        end else begin
            wr_valid <= t2[2] ^ t3[2];
            if (t2[2] ^ t3[2]) begin
                wr_data <= beat_l;
                wr_byte_en <= ben_l;
            end
        end
    end

    // read data drive, core domain
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            dq_out <= rd_data;
            dq_oe <= rd_valid;
        end
    end
endmodule

// *** dcd_regs.svh ***
// constants for the memory command decoder: field positions and widths
// assumes inclusion by dcd_decoder only, guarded
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH
`define DCD_BANKS 8
`define DCD_BA_W 3
`define DCD_ADDR_W 15
`define DCD_DQ_W 16
`define DCD_BYTE_W 8
`define DCD_AP_BIT 10
`define DCD_BC_BIT 12
`define DCD_BL8 4'h8
`define DCD_BC4 4'h4
`define DCD_MR_ONE 3'h1
`define DCD_MR_TWO 3'h2
// rtt fields of mode register one (a9,a6,a2) and two (a10:a9)
`define DCD_RTT_NOM_A 2
`define DCD_RTT_NOM_B 6
`define DCD_RTT_NOM_C 9
`define DCD_RTT_WR_LO 9
`define DCD_RTT_WR_HI 10
`endif

// *** dcd_pkg.sv ***
// types for the memory command decoder
// assumes dcd_regs.svh in the include path
package dcd_pkg;
    typedef enum logic [3:0] {
        dcd_nop = 4'h0,
        dcd_des = 4'h1,
        dcd_act = 4'h3,
        dcd_pre = 4'h2,
        dcd_prea = 4'h6,
        dcd_wr = 4'h7,
        dcd_rd = 4'h5,
        dcd_mrs = 4'h4,
        dcd_ref = 4'hc,
        dcd_sre = 4'hd,
        dcd_pde = 4'hf,
        dcd_pdx = 4'he,
        dcd_zqcl = 4'ha,
        dcd_zqcs = 4'hb,
        dcd_ill = 4'h9
    } dcd_cmd_e;
    // device power state, gray along idle->pd->sr
    typedef enum logic [1:0] {
        dcd_st_run = 2'b00,
        dcd_st_pd = 2'b01,
        dcd_st_sr = 2'b11
    } dcd_pwr_e;
endpackage

// *** dcd_decoder_asserts.sv ***
// checker on the decoder's core side outputs
// assumes bind onto dcd_decoder, one core clock domain
module dcd_decoder_asserts (
    // core clock and reset
    input wire logic clock,
    input wire logic resetn,
    // decoded results
    input dcd_pkg::dcd_cmd_e cmd,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_bank,
    input wire logic [14:0] cmd_addr,
    input wire logic [3:0] cmd_burst,
    input wire logic cmd_autopre,
    input wire logic [7:0] bank_open,
    input dcd_pkg::dcd_pwr_e pwr_state,
    input wire logic [1:0] wr_byte_en,
    input wire logic wr_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcd_pkg::*;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!resetn);
    // one decoded command of a given kind
    sequence s_cmd(c);
        cmd_valid && cmd == c;
    endsequence
    // a read or a write
    sequence s_rw;
        cmd_valid && (cmd == dcd_rd || cmd == dcd_wr);
    endsequence
    ////////////////////////////////////////////////////////////////
    burst_size_a: assert property (s_rw |-> cmd_burst inside {4'h8, 4'h4})
        else $error("burst length out of range");
    auto_pre_a: assert property (s_rw |-> cmd_autopre == cmd_addr[10])
        else $error("auto precharge flag wrong");
    zq_kind_a: assert property (cmd_valid && cmd inside {dcd_zqcl, dcd_zqcs}
        |-> cmd_addr[10] == (cmd == dcd_zqcl)) else $error("calibration kind");
    pre_kind_a: assert property (cmd_valid && cmd inside {dcd_pre, dcd_prea}
        |-> cmd_addr[10] == (cmd == dcd_prea)) else $error("precharge kind");
    act_open_a: assert property (s_cmd(dcd_act)
        |-> ##[0:4] bank_open[cmd_bank]) else $error("bank not opened");
    prea_close_a: assert property (s_cmd(dcd_prea)
        |-> ##[0:4] bank_open == 8'h00) else $error("banks not closed");
    pd_entry_a: assert property (s_cmd(dcd_pde)
        |-> ##[0:4] pwr_state == dcd_st_pd) else $error("no power down");
    sr_entry_a: assert property (s_cmd(dcd_sre)
        |-> ##[0:4] pwr_state == dcd_st_sr) else $error("no self refresh");
    wake_up_a: assert property (s_cmd(dcd_pdx)
        |-> ##[0:4] pwr_state == dcd_st_run) else $error("no wake up");
    wr_mask_a: assert property (wr_valid |-> wr_byte_en != 2'b00)
        else $error("fully masked word emitted");
    reset_clear_a: assert property (disable iff (1'b0) !resetn
        |-> !cmd_valid && !wr_valid && bank_open == 8'h00)
        else $error("outputs not cleared in reset");
endmodule
bind dcd_decoder dcd_decoder_asserts i_chk (.clock, .resetn, .cmd,
    .cmd_valid, .cmd_bank, .cmd_addr, .cmd_burst, .cmd_autopre,
    .bank_open, .pwr_state, .wr_byte_en, .wr_valid);

// *** dcd_ctrl_model.sv ***
// controller model driving the command and data pins
// assumes link_clock runs; pins change off the sampling edge
module dcd_ctrl_model (
    // link clock
    input wire logic link_clock,
    // command pins
    output logic cke,
    output logic [3:0] ctl_n,
    output logic [2:0] bank_addr,
    output logic [14:0] addr,
    output logic odt,
    // write data pins
    output logic [15:0] dq_in,
    output logic lower_byte_mask,
    output logic upper_byte_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: enable high, nop presented, writes masked
    initial begin
        cke = 1'b1;
        ctl_n = 4'b0111;
        bank_addr = 3'h0;
        addr = 15'h0000;
        odt = 1'b0;
        dq_in = 16'h0000;
        lower_byte_mask = 1'b1;
        upper_byte_mask = 1'b1;
    end
    // one command cycle, then nop with the enable kept
    task automatic send(input logic [3:0] code, input logic [2:0] ba,
        input logic [14:0] a, input logic ck);
        @(negedge link_clock);
        ctl_n = code;
        bank_addr = ba;
        addr = a;
        cke = ck;
        @(negedge link_clock);
        ctl_n = 4'b0111; // nop between commands
        bank_addr = ~ba;
        addr = ~a;
    endtask
    // one word held over a falling edge, then released
    task automatic beat(input logic [15:0] w, input logic [1:0] m);
        @(posedge link_clock);
        #4;
        dq_in = w;
        {upper_byte_mask, lower_byte_mask} = m;
        @(posedge link_clock);
        #4;
        dq_in = ~w;
        {upper_byte_mask, lower_byte_mask} = 2'b11;
    endtask
endmodule

// *** dcd_decoder_tb.sv ***
// self-checking bench for the command decoder
// assumes dcd_ctrl_model drives the pins, checker bound separately
module dcd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcd_pkg::*;
    localparam logic [3:0] ACT = 4'b0011, PRE = 4'b0010, WR = 4'b0100;
    localparam logic [3:0] RD = 4'b0101, MRS = 4'b0000, REF = 4'b0001;
    localparam logic [3:0] ZQ = 4'b0110, NOP = 4'b0111, DES = 4'b1111;
    logic clock, resetn, link_clock, cke, odt, lm, um, rd_valid, dq_oe;
    logic cmd_valid, cmd_autopre, odt_on, wr_valid;
    logic [3:0] ctl_n, cmd_burst;
    logic [2:0] bank_addr, cmd_bank, b;
    logic [14:0] addr, cmd_addr, a;
    logic [15:0] dq_in, dq_out, rd_data, wr_data, got_w, w;
    logic [7:0] bank_open;
    logic [1:0] wr_byte_en, got_be, m, be;
    dcd_cmd_e cmd;
    dcd_pwr_e pwr_state;
    int n_errors = 0, checks_done = 0, n_cmd = 0, n_wr = 0, pulses, i;
    int n0;
    logic [31:0] seed;
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        link_clock = 1'b0;
        #7;
        forever #16 link_clock = ~link_clock;
    end
    dcd_ctrl_model i_ctl (.link_clock(link_clock), .cke(cke),
        .ctl_n(ctl_n), .bank_addr(bank_addr), .addr(addr), .odt(odt),
        .dq_in(dq_in), .lower_byte_mask(lm), .upper_byte_mask(um));
    dcd_decoder i_dut (.clock(clock), .resetn(resetn),
        .link_clock(link_clock), .cke(cke), .cs_n(ctl_n[3]),
        .ras_n(ctl_n[2]), .cas_n(ctl_n[1]), .we_n(ctl_n[0]),
        .bank_addr(bank_addr), .addr(addr), .odt(odt), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .lower_byte_mask(lm),
        .upper_byte_mask(um), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd(cmd), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .cmd_burst(cmd_burst),
        .cmd_autopre(cmd_autopre), .bank_open(bank_open),
        .pwr_state(pwr_state), .odt_on(odt_on), .wr_data(wr_data),
        .wr_byte_en(wr_byte_en), .wr_valid(wr_valid));
    // counts command pulses, keeps the last written word
    always @(negedge clock) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (wr_valid === 1'b1) begin
            n_wr++;
            got_w = wr_data;
            got_be = wr_byte_en;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // sends one command, waits for its pulse under a bound
    task automatic issue(input logic [3:0] c, input logic [2:0] ba,
        input logic [14:0] ad, input logic ck);
        int k;
        k = n_cmd;
        i_ctl.send(c, ba, ad, ck);
        for (int j = 0; j < 20 && n_cmd == k; j++) @(negedge clock);
        repeat (3) @(negedge clock);
        pulses = n_cmd - k;
    endtask
    // burst for mode 0 fixed eight, 1 on the fly, 2 fixed chop
    function automatic logic [3:0] burst_of(int md, logic a12);
        return (md == 2 || (md == 1 && !a12)) ? 4'h4 : 4'h8;
    endfunction
    function automatic logic [15:0] keep(logic [1:0] e);
        return {{8{e[1]}}, {8{e[0]}}};
    endfunction
    initial begin
        #3_000_000;
        n_errors++;
        test_done;
    end
    initial begin
        seed = 32'h514b321d;
        resetn = 1'b0;
        rd_data = 16'h0000;
        rd_valid = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1; // held high for normal operation
        repeat (4) @(negedge clock);
        check(cmd_burst, 4'h8);
        check(pwr_state, dcd_st_run);
        issue(MRS, 3'h2, 15'h0000, 1'b1);
        issue(MRS, 3'h1, 15'h0001, 1'b1);
        check(cmd, dcd_mrs);
        i_ctl.odt = 1'b1;
        repeat (10) @(negedge clock);
        check(odt_on, 1'b0);
        issue(MRS, 3'h1, 15'h0005, 1'b1);
        check(odt_on, 1'b1);
        i_ctl.odt = 1'b0;
        repeat (10) @(negedge clock);
        check(odt_on, 1'b0);
        b = $random(seed);
        issue(RD, b, 15'h0000, 1'b1);
        check(cmd, dcd_ill);
        a = $random(seed);
        issue(ACT, b, a, 1'b1);
        check({cmd, cmd_bank, cmd_addr}, {dcd_act, b, a});
        check(bank_open, 8'h01 << b);
        issue(DES & ACT | 4'b1000, b ^ 3'h1, a, 1'b1);
        check(pulses, 0);
        check(bank_open, 8'h01 << b);
        for (i = 0; i < 6; i++) begin
            a = $random(seed);
            a[10] = 1'b0;
            w[0] = $random(seed);
            issue(w[0] ? RD : WR, b, a, 1'b1);
            check(cmd, w[0] ? dcd_rd : dcd_wr);
            check(cmd_burst, burst_of(1, a[12]));
        end
        for (i = 0; i < 4; i++) begin
            m = i;
            be = ~m;
            w = $random(seed);
            n0 = n_wr;
            issue(WR, b, 15'h1000, 1'b1);
            i_ctl.beat(w, m);
            repeat (8) @(negedge clock);
            check(n_wr - n0, (m == 2'b11) ? 0 : 1);
            if (m != 2'b11) check(got_be, be);
            if (m != 2'b11) check(got_w & keep(be), w & keep(be));
        end
        rd_data = $random(seed);
        rd_valid = 1'b1;
        @(negedge clock);
        check({dq_oe, dq_out}, {1'b1, rd_data});
        rd_valid = 1'b0;
        repeat (2) @(negedge clock);
        check(dq_oe, 1'b0);
        issue(RD, b, 15'h0400, 1'b1);
        check(cmd_autopre, 1'b1);
        repeat (20) @(negedge clock);
        check(bank_open[b], 1'b0);
        issue(ACT, b, a, 1'b1);
        issue(ACT, b ^ 3'h1, a, 1'b1);
        issue(PRE, b, 15'h0000, 1'b1);
        check(cmd, dcd_pre);
        check(bank_open, 8'h01 << (b ^ 3'h1));
        issue(PRE, b ^ 3'h1, 15'h0000, 1'b1);
        issue(MRS, 3'h1, 15'h0002, 1'b1);
        issue(ACT, b, a, 1'b1);
        issue(WR, b, 15'h1000, 1'b1);
        check(cmd_burst, burst_of(2, 1'b1));
        issue(PRE, b, 15'h0400, 1'b1);
        check({cmd, bank_open}, {dcd_prea, 8'h00});
        issue(REF, b, a, 1'b1);
        check(cmd, dcd_ref);
        for (i = 0; i < 2; i++) begin
            issue(ZQ, b, i ? 15'h0400 : 15'h0000, 1'b1);
            check(cmd, i ? dcd_zqcl : dcd_zqcs);
        end
        issue(NOP, b, a, 1'b0);
        check({cmd, pwr_state}, {dcd_pde, dcd_st_pd});
        issue(NOP, b, a, 1'b1);
        check({cmd, pwr_state}, {dcd_pdx, dcd_st_run});
        issue(REF, b, a, 1'b0);
        check({cmd, pwr_state}, {dcd_sre, dcd_st_sr});
        issue(DES, b, a, 1'b1);
        check(pwr_state, dcd_st_run);
        issue(DES, b, a, 1'b0);
        check({cmd, pwr_state}, {dcd_pde, dcd_st_pd});
        issue(NOP, b, a, 1'b1);
        check({cmd, pwr_state}, {dcd_pdx, dcd_st_run});
        issue(ACT, b, a, 1'b1);
        resetn = 1'b0;
        #1;
        check(bank_open, 8'h00);
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        repeat (6) @(negedge clock);
        check({bank_open, cmd_burst}, {8'h00, 4'h8});
        issue(ACT, b, a, 1'b1);
        issue(WR, b, 15'h0000, 1'b1);
        check(cmd_burst, burst_of(0, 1'b0));
        test_done;
    end
endmodule
